// ### src/blsnv_defs.vh
// blsnv_defs.vh: constants for the boot select and boot memory loader
// assumes inclusion by bare name from every blsnv design file
`ifndef BLSNV_DEFS_VH
`define BLSNV_DEFS_VH

// system clock
`define BLSNV_CLK_PERIOD_NS 20
// oscillator detection wait, in microseconds, and its cycle count
`define BLSNV_OSC_WAIT_US 1000
`define BLSNV_OSC_WAIT_CYC ((`BLSNV_OSC_WAIT_US * 1000) / `BLSNV_CLK_PERIOD_NS)

// first fetch address after reset and after the remap
`define BLSNV_FETCH_ADDR 32'h0000_0000

// main clock source codes
`define BLSNV_MAIN_FASTRC 2'h0
`define BLSNV_MAIN_SLOWRC 2'h1
`define BLSNV_MAIN_OSC 2'h2
// master clock source codes
`define BLSNV_MCK_SLOW 2'h0
`define BLSNV_MCK_MAIN 2'h1
`define BLSNV_MCK_PLL 2'h2

// main pll setup for 96 MHz processor clock, master clock at half of it
`define BLSNV_PLL_MUL 8'h08
`define BLSNV_PLL_DIV 8'h01
`define BLSNV_MCK_DIV_2 2'h1
`define BLSNV_MCK_DIV_1 2'h0
`define BLSNV_MCK_PRESC_NONE 3'h0

// frequency window, in kHz, treated as a 12 MHz reference
`define BLSNV_FREQ_LO_KHZ 16'h0FA0
`define BLSNV_FREQ_HI_KHZ 16'h6D60

// boot sources in try order, one bit each
`define BLSNV_SRC_SPI_SEL0 0
`define BLSNV_SRC_SD 1
`define BLSNV_SRC_NAND 2
`define BLSNV_SRC_SPI_SEL1 3
`define BLSNV_SRC_EEPROM 4
`define BLSNV_SRC_COUNT 3'h5

// exception vector check
`define BLSNV_VEC_COUNT 3'h7
`define BLSNV_VEC_LEN_IDX 3'h5
`define BLSNV_COND_ALWAYS 4'hE
`define BLSNV_REG_PC 4'hF
`define BLSNV_OPC_BRANCH 4'hA

// image limit and internal sram geometry
`define BLSNV_IMG_MAX 32'h0000_6000
`define BLSNV_SRAM_AW 13
`define BLSNV_SRAM_DEPTH 6144

`endif

// ### src/blsnv_vec_check.v
// blsnv_vec_check.v: classifies one exception vector word
// assumes a word as read from the boot memory, little end already resolved
`timescale 1ns/1ps
`include "blsnv_defs.vh"

module blsnv_vec_check (
  input wire [31:0] i_word,
  output wire o_is_branch,
  output wire o_is_ldr_pc
);

  wire cond_ok;

  assign cond_ok = (i_word[31:28] == `BLSNV_COND_ALWAYS);
  assign o_is_branch = cond_ok && (i_word[27:24] == `BLSNV_OPC_BRANCH);
  // up/down bit 23 left free on purpose
  assign o_is_ldr_pc = cond_ok && (i_word[27:26] == 2'h1) && !i_word[25] && i_word[24] &&
                       i_word[21] && (i_word[19:16] == `BLSNV_REG_PC) &&
                       (i_word[15:12] == `BLSNV_REG_PC);

endmodule // blsnv_vec_check

// ### src/blsnv_sram.v
// blsnv_sram.v: internal sram that receives the boot image
// assumes one write port from the loader and one read port, registered data
`timescale 1ns/1ps
`include "blsnv_defs.vh"

module blsnv_sram (
  input wire i_clk_sys,
  input wire i_we,
  input wire [`BLSNV_SRAM_AW-1:0] i_waddr,
  input wire [31:0] i_wdata,
  input wire [`BLSNV_SRAM_AW-1:0] i_raddr,
  output reg [31:0] o_rdata
);

  reg [31:0] mem [0:`BLSNV_SRAM_DEPTH-1];

  // no reset on the array; contents are only meaningful after a copy
  always @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule // blsnv_sram

// ### src/blsnv_boot_loader.v
// blsnv_boot_loader.v: boot select capture, clock setup and boot memory loader
// assumes all inputs synchronous to i_clk_sys; memory protocols live outside
`timescale 1ns/1ps
`include "blsnv_defs.vh"

module blsnv_boot_loader #(
  parameter OSC_WAIT_CYC = `BLSNV_OSC_WAIT_CYC
) (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_boot_select_pin,
  input wire [2:0] i_boot_sequence_config,
  input wire i_osc_select_status,
  input wire i_crystal_stable_status,
  input wire i_mck_ready,
  input wire [15:0] i_main_freq_khz,
  input wire i_src_init_done,
  input wire i_src_init_ok,
  input wire i_src_is_file,
  input wire [31:0] i_src_file_size,
  input wire i_rd_valid,
  input wire [31:0] i_rd_data,
  input wire [`BLSNV_SRAM_AW-1:0] i_sram_rd_addr,
  output wire [31:0] o_sram_rd_data,
  output reg o_boot_from_cs0,
  output reg o_rom_mapped,
  output reg o_sram_remap,
  output reg o_cpu_start,
  output reg [31:0] o_fetch_addr,
  output reg [1:0] o_main_clk_src,
  output reg o_osc_enable,
  output reg o_osc_bypass,
  output reg [1:0] o_mck_src,
  output reg [2:0] o_mck_presc,
  output reg [1:0] o_mck_div,
  output reg o_pll_enable,
  output reg [7:0] o_pll_mul,
  output reg [7:0] o_pll_div,
  output reg o_usb_enable,
  output reg [4:0] o_src_sel,
  output reg o_src_setup,
  output reg o_src_restore,
  output wire o_rd_req,
  output reg [15:0] o_rd_addr,
  output reg o_monitor_run,
  output wire o_loader_busy
);

  localparam [14:0] S_CAP = 15'h0001;
  localparam [14:0] S_CS0 = 15'h0002;
  localparam [14:0] S_OSC_BYP = 15'h0004;
  localparam [14:0] S_OSC_XT = 15'h0008;
  localparam [14:0] S_MCK = 15'h0010;
  localparam [14:0] S_PLL = 15'h0020;
  localparam [14:0] S_PLL_WAIT = 15'h0040;
  localparam [14:0] S_NEXT = 15'h0080;
  localparam [14:0] S_SETUP = 15'h0100;
  localparam [14:0] S_VEC = 15'h0200;
  localparam [14:0] S_COPY = 15'h0400;
  localparam [14:0] S_REMAP = 15'h0800;
  localparam [14:0] S_RESTORE = 15'h1000;
  localparam [14:0] S_MON = 15'h2000;
  localparam [14:0] S_RUN = 15'h4000;

  localparam [15:0] OSC_WAIT = OSC_WAIT_CYC[15:0];

  reg [14:0] state_q;
  reg [15:0] timer_q;
  reg ext_clk_q;
  reg [2:0] src_idx_q;
  reg [2:0] vec_idx_q;
  reg vec_bad_q;
  reg [31:0] img_len_q;
  reg [`BLSNV_SRAM_AW-1:0] word_q;
  reg [`BLSNV_SRAM_AW-1:0] words_q;
  reg sram_we_q;
  reg [`BLSNV_SRAM_AW-1:0] sram_waddr_q;
  reg [31:0] sram_wdata_q;

  wire is_branch;
  wire is_ldr_pc;
  wire [4:0] src_mask;
  wire freq_12m;
  wire take_word;

  // which sources a sequence value lets through
  function [4:0] seq_mask;
    input [2:0] cfg;
    begin
      case (cfg)
        3'h0: seq_mask = 5'h1F;
        3'h1: seq_mask = 5'h1D;
        3'h2: seq_mask = 5'h19;
        3'h3: seq_mask = 5'h19;
        3'h4: seq_mask = 5'h11;
        default: seq_mask = 5'h00;
      endcase
    end
  endfunction

  // byte length to whole words, limited to the sram index width
  function [`BLSNV_SRAM_AW-1:0] len_words;
    input [31:0] len;
    reg [31:0] w;
    begin
      w = (len + 32'h0000_0003) >> 2;
      len_words = w[`BLSNV_SRAM_AW-1:0];
    end
  endfunction

  function [4:0] one_src;
    input [2:0] idx;
    begin
      one_src = 5'h01 << idx;
    end
  endfunction

  assign src_mask = seq_mask(i_boot_sequence_config);
  // the window bounds are taken inclusive
  assign freq_12m = ext_clk_q && (i_main_freq_khz >= `BLSNV_FREQ_LO_KHZ) &&
                    (i_main_freq_khz <= `BLSNV_FREQ_HI_KHZ);
  assign o_rd_req = (state_q == S_VEC) || ((state_q == S_COPY) && (word_q != words_q));
  assign take_word = o_rd_req && i_rd_valid;
  assign o_loader_busy = !((state_q == S_RUN) || (state_q == S_MON) || (state_q == S_CS0));

  blsnv_vec_check u_vec_check (
    .i_word(i_rd_data),
    .o_is_branch(is_branch),
    .o_is_ldr_pc(is_ldr_pc)
  );

  blsnv_sram u_sram (
    .i_clk_sys(i_clk_sys),
    .i_we(sram_we_q),
    .i_waddr(sram_waddr_q),
    .i_wdata(sram_wdata_q),
    .i_raddr(i_sram_rd_addr),
    .o_rdata(o_sram_rd_data)
  );

  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= S_CAP;
      timer_q <= 16'h0000;
      ext_clk_q <= 1'b0;
      src_idx_q <= 3'h0;
      vec_idx_q <= 3'h0;
      vec_bad_q <= 1'b0;
      img_len_q <= 32'h0000_0000;
      word_q <= {`BLSNV_SRAM_AW{1'b0}};
      words_q <= {`BLSNV_SRAM_AW{1'b0}};
      sram_we_q <= 1'b0;
      sram_waddr_q <= {`BLSNV_SRAM_AW{1'b0}};
      sram_wdata_q <= 32'h0000_0000;
      o_boot_from_cs0 <= 1'b0;
      o_rom_mapped <= 1'b0;
      o_sram_remap <= 1'b0;
      o_cpu_start <= 1'b0;
      o_fetch_addr <= `BLSNV_FETCH_ADDR;
      o_main_clk_src <= `BLSNV_MAIN_FASTRC;
      o_osc_enable <= 1'b0;
      o_osc_bypass <= 1'b0;
      o_mck_src <= `BLSNV_MCK_MAIN;
      o_mck_presc <= `BLSNV_MCK_PRESC_NONE;
      o_mck_div <= `BLSNV_MCK_DIV_1;
      o_pll_enable <= 1'b0;
      o_pll_mul <= 8'h00;
      o_pll_div <= 8'h00;
      o_usb_enable <= 1'b0;
      o_src_sel <= 5'h00;
      o_src_setup <= 1'b0;
      o_src_restore <= 1'b0;
      o_rd_addr <= 16'h0000;
      o_monitor_run <= 1'b0;
    end
    else
    begin
      o_cpu_start <= 1'b0;
      o_src_setup <= 1'b0;
      o_src_restore <= 1'b0;
      sram_we_q <= 1'b0;
      case (state_q)
        S_CAP:
        begin
          // first edge after release is the only look at the pin
          if (!i_boot_select_pin)
          begin
            o_boot_from_cs0 <= 1'b1;
            state_q <= S_CS0;
          end
          else
          begin
            o_rom_mapped <= 1'b1;
            o_main_clk_src <= `BLSNV_MAIN_SLOWRC;
            o_mck_src <= `BLSNV_MCK_SLOW;
            o_osc_enable <= 1'b1;
            o_osc_bypass <= 1'b1;
            timer_q <= OSC_WAIT;
            state_q <= S_OSC_BYP;
          end
        end
        S_CS0:
        begin
          // clocks and memory timing stay at reset values here
          o_cpu_start <= 1'b1;
          state_q <= S_RUN;
        end
        S_OSC_BYP:
        begin
          if (i_osc_select_status)
          begin
            ext_clk_q <= 1'b1;
            o_main_clk_src <= `BLSNV_MAIN_OSC;
            o_mck_src <= `BLSNV_MCK_MAIN;
            o_mck_presc <= `BLSNV_MCK_PRESC_NONE;
            state_q <= S_MCK;
          end
          else if (timer_q == 16'h0000)
          begin
            o_osc_bypass <= 1'b0;
            timer_q <= OSC_WAIT;
            state_q <= S_OSC_XT;
          end
          else
          begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        S_OSC_XT:
        begin
          if (i_osc_select_status && i_crystal_stable_status)
          begin
            ext_clk_q <= 1'b1;
            o_main_clk_src <= `BLSNV_MAIN_OSC;
            o_mck_src <= `BLSNV_MCK_MAIN;
            o_mck_presc <= `BLSNV_MCK_PRESC_NONE;
            state_q <= S_MCK;
          end
          else if (timer_q == 16'h0000)
          begin
            // no reference at all: go back from the slow rc to the fast rc
            o_osc_enable <= 1'b0;
            o_main_clk_src <= `BLSNV_MAIN_FASTRC;
            o_mck_src <= `BLSNV_MCK_MAIN;
            o_mck_presc <= `BLSNV_MCK_PRESC_NONE;
            state_q <= S_MCK;
          end
          else
          begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        S_MCK:
        begin
          if (i_mck_ready)
          begin
            state_q <= S_PLL;
          end
        end
        S_PLL:
        begin
          if (freq_12m)
          begin
            o_usb_enable <= 1'b1;
          end
          else
          begin
            o_usb_enable <= 1'b0;
            o_main_clk_src <= `BLSNV_MAIN_FASTRC;
          end
          o_pll_enable <= 1'b1;
          o_pll_mul <= `BLSNV_PLL_MUL;
          o_pll_div <= `BLSNV_PLL_DIV;
          o_mck_div <= `BLSNV_MCK_DIV_2;
          o_mck_src <= `BLSNV_MCK_PLL;
          state_q <= S_PLL_WAIT;
        end
        S_PLL_WAIT:
        begin
          if (i_mck_ready)
          begin
            src_idx_q <= 3'h0;
            state_q <= S_NEXT;
          end
        end
        S_NEXT:
        begin
          if (src_idx_q >= `BLSNV_SRC_COUNT)
          begin
            o_monitor_run <= 1'b1;
            o_cpu_start <= 1'b1;
            state_q <= S_MON;
          end
          else if (src_mask[src_idx_q])
          begin
            o_src_sel <= one_src(src_idx_q);
            o_src_setup <= 1'b1;
            state_q <= S_SETUP;
          end
          else
          begin
            src_idx_q <= src_idx_q + 3'h1;
          end
        end
        S_SETUP:
        begin
          if (i_src_init_done)
          begin
            o_rd_addr <= 16'h0000;
            vec_idx_q <= 3'h0;
            vec_bad_q <= 1'b0;
            word_q <= {`BLSNV_SRAM_AW{1'b0}};
            if (!i_src_init_ok)
            begin
              state_q <= S_RESTORE;
            end
            else if (i_src_is_file)
            begin
              // a file carries its size; no vector check
              if (i_src_file_size <= `BLSNV_IMG_MAX)
              begin
                words_q <= len_words(i_src_file_size);
                state_q <= S_COPY;
              end
              else
              begin
                state_q <= S_RESTORE;
              end
            end
            else
            begin
              state_q <= S_VEC;
            end
          end
        end
        S_VEC:
        begin
          if (take_word)
          begin
            if (vec_idx_q == `BLSNV_VEC_LEN_IDX)
            begin
              img_len_q <= i_rd_data;
            end
            else if (!(is_branch || is_ldr_pc))
            begin
              vec_bad_q <= 1'b1;
            end
            if (vec_idx_q == `BLSNV_VEC_COUNT - 3'h1)
            begin
              o_rd_addr <= 16'h0000;
              // a bad last word lands here too, so judge it directly
              if (vec_bad_q || !(is_branch || is_ldr_pc) ||
                  (img_len_q >= `BLSNV_IMG_MAX))
              begin
                state_q <= S_RESTORE;
              end
              else
              begin
                words_q <= len_words(img_len_q);
                state_q <= S_COPY;
              end
            end
            else
            begin
              vec_idx_q <= vec_idx_q + 3'h1;
              o_rd_addr <= o_rd_addr + 16'h0004;
            end
          end
        end
        S_COPY:
        begin
          if (word_q == words_q)
          begin
            o_sram_remap <= 1'b1;
            o_rom_mapped <= 1'b0;
            state_q <= S_REMAP;
          end
          else if (take_word)
          begin
            sram_we_q <= 1'b1;
            sram_waddr_q <= word_q;
            sram_wdata_q <= i_rd_data;
            word_q <= word_q + {{(`BLSNV_SRAM_AW-1){1'b0}}, 1'b1};
            o_rd_addr <= o_rd_addr + 16'h0004;
          end
        end
        S_REMAP:
        begin
          // remap has settled one cycle before the core is released
          o_fetch_addr <= `BLSNV_FETCH_ADDR;
          o_cpu_start <= 1'b1;
          state_q <= S_RUN;
        end
        S_RESTORE:
        begin
          o_src_restore <= 1'b1;
          o_src_sel <= 5'h00;
          src_idx_q <= src_idx_q + 3'h1;
          state_q <= S_NEXT;
        end
        S_MON:
        begin
          state_q <= S_MON;
        end
        S_RUN:
        begin
          state_q <= S_RUN;
        end
        default:
        begin
          state_q <= S_CAP;
        end
      endcase
    end
  end

endmodule // blsnv_boot_loader

// ### verification/blsnv_props.sv
// blsnv_props.sv: port-level checks on the boot select and boot memory loader
// assumes bind onto blsnv_boot_loader, a single clock domain and an active-low reset
`timescale 1ns/1ps
module blsnv_props (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire [2:0] i_boot_sequence_config,
  input wire [15:0] i_main_freq_khz,
  input wire o_boot_from_cs0,
  input wire o_rom_mapped,
  input wire o_sram_remap,
  input wire o_cpu_start,
  input wire [31:0] o_fetch_addr,
  input wire [1:0] o_main_clk_src,
  input wire o_osc_enable,
  input wire o_osc_bypass,
  input wire [1:0] o_mck_src,
  input wire [1:0] o_mck_div,
  input wire o_pll_enable,
  input wire [7:0] o_pll_mul,
  input wire [7:0] o_pll_div,
  input wire o_usb_enable,
  input wire [4:0] o_src_sel,
  input wire o_src_setup,
  input wire o_monitor_run
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_fetch_zero;
    o_fetch_addr == 32'h0;
  endproperty
  a_fetch_zero: assert property (p_fetch_zero) else $error("fetch address not zero");
  property p_cs0_hold;
    o_boot_from_cs0 |=> o_boot_from_cs0 && !o_rom_mapped;
  endproperty
  a_cs0_hold: assert property (p_cs0_hold) else $error("captured boot select changed");
  property p_cs0_start;
    $rose(o_boot_from_cs0) |=> o_cpu_start && o_main_clk_src == 2'h0 && !o_osc_enable;
  endproperty
  a_cs0_start: assert property (p_cs0_start) else $error("chip select boot not at defaults");
  property p_rom_entry;
    $rose(o_rom_mapped) |-> o_main_clk_src == 2'h1 && o_osc_enable && o_osc_bypass && o_mck_src == 2'h0;
  endproperty
  a_rom_entry: assert property (p_rom_entry) else $error("loader entry clock setup wrong");
  property p_pll_set;
    $rose(o_pll_enable) |-> o_pll_mul == 8'h08 && o_pll_div == 8'h01 && o_mck_div == 2'h1 && o_mck_src == 2'h2;
  endproperty
  a_pll_set: assert property (p_pll_set) else $error("pll setup wrong");
  // usb only on a main oscillator inside the window that counts as the usb reference
  property p_usb_ref;
    o_usb_enable |-> o_main_clk_src == 2'h2 && i_main_freq_khz >= 16'h0FA0 && i_main_freq_khz <= 16'h6D60;
  endproperty
  a_usb_ref: assert property (p_usb_ref) else $error("usb on without reference");
  property p_seq_mask;
    o_src_setup |-> $onehot(o_src_sel) && i_boot_sequence_config < 3'h5
      && !(o_src_sel[1] && i_boot_sequence_config != 3'h0) && !(o_src_sel[2] && i_boot_sequence_config > 3'h1)
      && !(o_src_sel[3] && i_boot_sequence_config == 3'h4);
  endproperty
  a_seq_mask: assert property (p_seq_mask) else $error("disabled source tried");
  property p_remap;
    $rose(o_sram_remap) |-> !o_rom_mapped ##1 o_cpu_start;
  endproperty
  a_remap: assert property (p_remap) else $error("remap not followed by start");
  property p_monitor;
    $rose(o_monitor_run) |-> o_cpu_start && !o_sram_remap && o_src_sel == 5'h00;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor start wrong");
endmodule // blsnv_props

bind blsnv_boot_loader blsnv_props u_props (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_boot_sequence_config(i_boot_sequence_config), .i_main_freq_khz(i_main_freq_khz),
  .o_boot_from_cs0(o_boot_from_cs0), .o_rom_mapped(o_rom_mapped), .o_sram_remap(o_sram_remap),
  .o_cpu_start(o_cpu_start), .o_fetch_addr(o_fetch_addr), .o_main_clk_src(o_main_clk_src),
  .o_osc_enable(o_osc_enable), .o_osc_bypass(o_osc_bypass), .o_mck_src(o_mck_src), .o_mck_div(o_mck_div),
  .o_pll_enable(o_pll_enable), .o_pll_mul(o_pll_mul), .o_pll_div(o_pll_div), .o_usb_enable(o_usb_enable),
  .o_src_sel(o_src_sel), .o_src_setup(o_src_setup), .o_monitor_run(o_monitor_run));

// ### verification/blsnv_mem_model.sv
// blsnv_mem_model.sv: boot memories behind the loader, answers setup and word reads
// assumes the bench loads img and the masks while reset is held
`timescale 1ns/1ps
module blsnv_mem_model (
  input wire i_clk_sys,
  input wire i_resetn,
  input wire i_src_setup,
  input wire [4:0] i_src_sel,
  input wire i_rd_req,
  input wire [15:0] i_rd_addr,
  input wire [4:0] i_ok_mask,
  input wire [4:0] i_bad_mask,
  input wire [4:0] i_file_mask,
  input wire [31:0] i_file_size,
  input wire i_slow,
  output wire o_init_done,
  output wire o_init_ok,
  output wire o_is_file,
  output wire [31:0] o_file_size,
  output wire o_rd_valid,
  output wire [31:0] o_rd_data
);
  logic [31:0] img [0:7];
  logic [4:0] sel_q;
  logic [1:0] cnt_q;
  logic done_q;
  logic tog_q;
  wire bad_w = |(sel_q & i_bad_mask) && i_rd_addr[15:2] == 14'h0;
  wire [31:0] word_w = img[i_rd_addr[4:2]] ^ (bad_w ? 32'hF000_0000 : 32'h0);
  always @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sel_q <= 5'h00;
      cnt_q <= 2'h0;
      done_q <= 1'b0;
      tog_q <= 1'b0;
    end
    else
    begin
      // setup takes a few cycles, like a real peripheral bring-up
      if (i_src_setup)
        sel_q <= i_src_sel;
      cnt_q <= i_src_setup ? 2'h3 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
      done_q <= cnt_q == 2'h1;
      tog_q <= ~tog_q;
    end
  end
  assign o_init_done = done_q;
  assign o_init_ok = |(sel_q & i_ok_mask);
  assign o_is_file = |(sel_q & i_file_mask);
  assign o_file_size = i_file_size;
  assign o_rd_valid = i_rd_req && (!i_slow || tog_q);
  // no word on offer: show the inverse so a stale value never passes as data
  assign o_rd_data = o_rd_valid ? word_w : ~word_w;
endmodule // blsnv_mem_model

// ### verification/test_boot_select_and_nvm_loader.sv
// test_boot_select_and_nvm_loader.sv: self-checking bench for blsnv_boot_loader
// assumes blsnv_mem_model as boot memories; clock manager status is made here
`timescale 1ns/1ps
module test_boot_select_and_nvm_loader;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_boot_select_pin = 1'b0;
  logic [2:0] i_boot_sequence_config = 3'h0;
  logic i_osc_select_status = 1'b0;
  logic i_crystal_stable_status = 1'b0;
  logic i_mck_ready = 1'b0;
  logic [15:0] i_main_freq_khz = 16'h0;
  logic [12:0] i_sram_rd_addr = 13'h0;
  logic [1:0] clk_mode = 2'h0;
  logic [1:0] mck_prev = 2'h1;
  logic [4:0] ok_mask = 5'h0;
  logic [4:0] bad_mask = 5'h0;
  logic [4:0] file_mask = 5'h0;
  logic [31:0] fsize = 32'h0;
  logic slow = 1'b0;
  logic [31:0] img [0:7];
  wire i_src_init_done, i_src_init_ok, i_src_is_file, i_rd_valid;
  wire [31:0] i_src_file_size, i_rd_data, o_sram_rd_data, o_fetch_addr;
  wire o_boot_from_cs0, o_rom_mapped, o_sram_remap, o_cpu_start, o_osc_enable, o_osc_bypass, o_pll_enable;
  wire o_usb_enable, o_src_setup, o_src_restore, o_rd_req, o_monitor_run, o_loader_busy;
  wire [1:0] o_main_clk_src, o_mck_src, o_mck_div;
  wire [2:0] o_mck_presc;
  wire [7:0] o_pll_mul, o_pll_div;
  wire [4:0] o_src_sel;
  wire [15:0] o_rd_addr;
  integer err_count = 0;
  integer n_compared = 0;
  integer n_setup = 0;
  integer n_restore = 0;
  int exp_setups [0:7] = '{5, 4, 3, 3, 2, 0, 0, 0};

  always #10 i_clk_sys = ~i_clk_sys;

  blsnv_boot_loader #(.OSC_WAIT_CYC(20)) DUT (.i_clk_sys, .i_resetn, .i_boot_select_pin, .i_boot_sequence_config,
    .i_osc_select_status, .i_crystal_stable_status, .i_mck_ready, .i_main_freq_khz, .i_src_init_done,
    .i_src_init_ok, .i_src_is_file, .i_src_file_size, .i_rd_valid, .i_rd_data, .i_sram_rd_addr, .o_sram_rd_data,
    .o_boot_from_cs0, .o_rom_mapped, .o_sram_remap, .o_cpu_start, .o_fetch_addr, .o_main_clk_src, .o_osc_enable,
    .o_osc_bypass, .o_mck_src, .o_mck_presc, .o_mck_div, .o_pll_enable, .o_pll_mul, .o_pll_div, .o_usb_enable,
    .o_src_sel, .o_src_setup, .o_src_restore, .o_rd_req, .o_rd_addr, .o_monitor_run, .o_loader_busy);

  blsnv_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_src_setup(o_src_setup),
    .i_src_sel(o_src_sel), .i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr), .i_ok_mask(ok_mask), .i_bad_mask(bad_mask),
    .i_file_mask(file_mask), .i_file_size(fsize), .i_slow(slow), .o_init_done(i_src_init_done),
    .o_init_ok(i_src_init_ok), .o_is_file(i_src_is_file), .o_file_size(i_src_file_size), .o_rd_valid(i_rd_valid),
    .o_rd_data(i_rd_data));

  // ready drops for one cycle after any master clock switch, so a stale ready is never seen
  always @(negedge i_clk_sys)
  begin
    i_mck_ready <= o_mck_src === mck_prev;
    mck_prev <= o_mck_src;
    i_osc_select_status <= clk_mode == 2'h1 || (clk_mode == 2'h2 && o_osc_enable === 1'b1 && o_osc_bypass === 1'b0);
    i_crystal_stable_status <= clk_mode == 2'h2;
  end

  always @(posedge i_clk_sys)
  begin
    if (o_src_setup === 1'b1)
      n_setup <= n_setup + 1;
    if (o_src_restore === 1'b1)
      n_restore <= n_restore + 1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_compared++;
      if (got !== exp)
      begin
        err_count++;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (err_count == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task automatic boot(input logic pin, input logic [2:0] cfg, input logic [1:0] mode, input logic [15:0] freq,
    input logic [4:0] ok, input logic [4:0] bad, input logic [4:0] fil);
    integer k;
    begin
      @(negedge i_clk_sys);
      i_resetn = 1'b0;
      i_boot_select_pin = pin;
      i_boot_sequence_config = cfg;
      i_main_freq_khz = freq;
      clk_mode = mode;
      ok_mask = ok;
      bad_mask = bad;
      file_mask = fil;
      u_mem.img = img;
      n_setup = 0;
      n_restore = 0;
      repeat (5) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      for (k = 0; k < 8000 && o_cpu_start !== 1'b1; k++)
      begin
        @(posedge i_clk_sys);
        #1;
      end
      if (k == 8000)
      begin
        err_count++;
        report_and_stop;
      end
    end
  endtask

  task automatic chk_sram(input integer n);
    begin
      for (int w = 0; w < n; w++)
      begin
        @(negedge i_clk_sys);
        i_sram_rd_addr = w[12:0];
        @(posedge i_clk_sys);
        #1;
        chk("sram word", img[w], o_sram_rd_data);
      end
    end
  endtask

  initial
  begin
    img = '{32'hEA00_0006, 32'hE5BF_F018, 32'hEA00_002F, 32'hE53F_F018, 32'hEAFF_FFFE, 32'h0000_0020,
      32'hEAFF_FFFE, 32'h1234_5678};
    boot(1'b0, 3'h0, 2'h1, 16'h2EE0, 5'h1F, 5'h00, 5'h00);
    chk("cs0 boot", 32'h1, o_boot_from_cs0);
    chk("main src", 32'h0, o_main_clk_src);
    chk("mck src", 32'h1, o_mck_src);
    chk("fetch", 32'h0, o_fetch_addr);
    chk("busy", 32'h0, o_loader_busy);
    @(negedge i_clk_sys);
    i_boot_select_pin = 1'b1;
    repeat (40) @(negedge i_clk_sys);
    chk("rom late", 32'h0, o_rom_mapped);
    chk("setups late", 32'h0, n_setup);
    slow = 1'b1;
    boot(1'b1, 3'h0, 2'h1, 16'h2EE0, 5'h04, 5'h00, 5'h00);
    chk("sel", 32'h04, o_src_sel);
    chk("setups", 32'h3, n_setup);
    chk("restores", 32'h2, n_restore);
    chk("remap", 32'h1, o_sram_remap);
    chk("rom", 32'h0, o_rom_mapped);
    chk("main src", 32'h2, o_main_clk_src);
    chk("usb", 32'h1, o_usb_enable);
    chk("pll", 32'h0801, {o_pll_mul, o_pll_div});
    chk("mck", 32'h41, {o_mck_src, o_mck_presc, o_mck_div});
    chk_sram(8);
    slow = 1'b0;
    boot(1'b1, 3'h4, 2'h2, 16'h2EE0, 5'h10, 5'h00, 5'h00);
    chk("setups", 32'h2, n_setup);
    chk("sel", 32'h10, o_src_sel);
    chk("main src", 32'h2, o_main_clk_src);
    chk("usb", 32'h1, o_usb_enable);
    fsize = 32'h0000_001D;
    boot(1'b1, 3'h0, 2'h1, 16'h7530, 5'h03, 5'h01, 5'h02);
    chk("sel", 32'h02, o_src_sel);
    chk("restores", 32'h1, n_restore);
    chk("usb", 32'h0, o_usb_enable);
    chk("main src", 32'h0, o_main_clk_src);
    chk_sram(8);
    fsize = 32'h0000_6001;
    boot(1'b1, 3'h0, 2'h1, 16'h2EE0, 5'h02, 5'h00, 5'h02);
    chk("restores", 32'h5, n_restore);
    chk("monitor", 32'h1, o_monitor_run);
    for (int c = 0; c < 8; c++)
    begin
      boot(1'b1, c[2:0], 2'h0, 16'h2EE0, 5'h00, 5'h00, 5'h00);
      chk("setups", exp_setups[c], n_setup);
      chk("monitor", 32'h1, o_monitor_run);
      chk("main src", 32'h0, o_main_clk_src);
      chk("osc en", 32'h0, o_osc_enable);
      chk("rd req", 32'h0, o_rd_req);
      chk("busy", 32'h0, o_loader_busy);
    end
    for (int j = 0; j < 2; j++)
    begin
      img[5] = j ? 32'h0000_6000 : 32'h0000_5FFC;
      boot(1'b1, 3'h4, 2'h1, 16'h2EE0, 5'h01, 5'h00, 5'h00);
      chk("remap", j ? 32'h0 : 32'h1, o_sram_remap);
      chk("restores", j ? 32'h2 : 32'h0, n_restore);
    end
    report_and_stop;
  end
endmodule // test_boot_select_and_nvm_loader
